// ==== rtl/rpi_top.v ====
// reduced-interface pin block: straps, data pins, management, interrupt
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "rpi_consts.vh"
module rpi_top (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // reference clock toward the mac
  output wire        ref_clk_out,
  // receive pins, shared with straps
  output reg  [1:0]  rxd_o,
  output wire [1:0]  rxd_oe,
  input  wire [1:0]  rxd_i,
  output reg         crs_dv_o,
  output wire        crs_dv_oe,
  input  wire        crs_dv_i,
  output reg         rx_er_o,
  output wire        rx_er_oe,
  input  wire        rx_er_i,
  // transmit pins from the mac
  input  wire        tx_en,
  input  wire [1:0]  txd,
  // dedicated strap pins
  input  wire        station_address_bit0_pin,
  input  wire        station_address_bit1_pin,
  input  wire        interface_mode_strap_bit0,
  input  wire        interface_mode_strap_bit1,
  // management
  input  wire        mdc,
  input  wire        mdio_i,
  output reg         mdio_o,
  output reg         mdio_oe,
  // interrupt
  output reg         interrupt_output,
  // core side
  input  wire [1:0]  core_rx_dibit,
  input  wire        core_rx_dv,
  input  wire        core_rx_err,
  output reg  [1:0]  core_tx_dibit,
  output reg         core_tx_valid,
  output reg  [2:0]  station_address_strap
);

  localparam [31:0] STRAP_CYC = (`RPI_STRAP_TIME_NS + `RPI_CLK_PERIOD_NS - 1)
                                / `RPI_CLK_PERIOD_NS;
  localparam [31:0] STRAP_M1   = STRAP_CYC - 1;
  localparam [7:0]  STRAP_LAST = STRAP_M1[7:0];

  localparam [2:0] M_PRE  = 3'h0;
  localparam [2:0] M_HDR  = 3'h1;
  localparam [2:0] M_TA   = 3'h2;
  localparam [2:0] M_RDAT = 3'h3;
  localparam [2:0] M_WDAT = 3'h4;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [9:0] pin_s;
  rpi_sync #(.W(10)) u_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({mdc, mdio_i, rxd_i, crs_dv_i, rx_er_i,
             station_address_bit0_pin, station_address_bit1_pin,
             interface_mode_strap_bit0, interface_mode_strap_bit1}),
    .q     (pin_s)
  );

  wire mdc_s  = pin_s[9];
  wire mdio_s = pin_s[8];

  //////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  reg  [7:0]  strap_cnt_q;
  reg         strap_done_q;
  reg  [2:0]  mode_strap_q;
  reg         seta_strap_q;
  reg  [15:0] ctrl_q;
  reg  [15:0] ctrl2_q;
  reg  [`RPI_EV_W-1:0] int_en_q;
  reg  [`RPI_EV_W-1:0] status_q;

  // pins stay inputs until the window closes
  wire strap_win = !strap_done_q;                                 // RULE11
  wire seta_on   = ctrl_q[`RPI_CTRL_SETA_BIT];
  wire drive_rx  = !strap_win && !seta_on;                 // RULE11 RULE15

  assign rxd_oe    = {drive_rx, drive_rx};
  assign crs_dv_oe = drive_rx;
  assign rx_er_oe  = drive_rx;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q  <= 8'h00;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 8'h01;
      if (strap_cnt_q == STRAP_LAST)
        strap_done_q <= 1'b1;
    end
  end
  wire strap_latch = !strap_done_q && (strap_cnt_q == STRAP_LAST);

  // sampled late in the window so the synchroniser has settled
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      station_address_strap <= 3'h0;
      mode_strap_q          <= 3'h0;
      seta_strap_q          <= 1'b0;
    end else if (strap_latch) begin
      station_address_strap <= {pin_s[7], pin_s[2], pin_s[3]};    // RULE7
      mode_strap_q          <= {pin_s[5], pin_s[0], pin_s[1]};    // RULE10
      seta_strap_q          <= pin_s[4];                          // RULE9
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reference clock and data pins
  // forwarded clock, no divider needed at the native rate
  assign ref_clk_out = ref_clk;                                   // RULE3

  reg tx_en_d1_q;
  reg rx_dv_d1_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_o         <= 2'h0;
      crs_dv_o      <= 1'b0;
      rx_er_o       <= 1'b0;
      core_tx_dibit <= 2'h0;
      core_tx_valid <= 1'b0;
      tx_en_d1_q    <= 1'b0;
      rx_dv_d1_q    <= 1'b0;
    end else begin
      rxd_o         <= core_rx_dv ? core_rx_dibit : 2'h0;         // RULE1
      crs_dv_o      <= core_rx_dv;                                // RULE5
      rx_er_o       <= core_rx_err;                               // RULE6
      // mac pins share this clock, no synchroniser
      core_tx_dibit <= tx_en ? txd : 2'h0;                        // RULE2
      core_tx_valid <= tx_en;                                     // RULE2
      tx_en_d1_q    <= tx_en;
      rx_dv_d1_q    <= core_rx_dv;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // management frame engine
  reg  [2:0]  m_state_q;
  reg  [5:0]  pre_cnt_q;
  reg  [3:0]  bit_cnt_q;
  reg  [11:0] hdr_q;
  reg         m_rd_q;
  reg  [4:0]  m_idx_q;
  reg  [15:0] m_shift_q;
  reg         m_wr_pend_q;
  reg         mdc_d1_q;
  reg         m_wr_ev;

  wire        mdc_rise = mdc_s && !mdc_d1_q;                      // RULE14
  wire [12:0] hdr_full = {hdr_q, mdio_s};
  wire        hdr_hit  = hdr_full[12] &&
                         (hdr_full[9:5] == {2'h0, station_address_strap});

  wire        wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr  = wb_req && wb_we_i && !wb_adr_i[7];
  wire        m_serve = m_wr_pend_q && !wb_wr;

  function [15:0] reg_rd;
    input [4:0] idx;
    begin
      case (idx)
        `RPI_IDX_CTRL:   reg_rd = ctrl_q;
        `RPI_IDX_STRAP:  reg_rd = {9'h000, seta_strap_q, mode_strap_q,
                                   station_address_strap};
        `RPI_IDX_INT_CS: reg_rd = {3'h0, int_en_q, 3'h0, status_q}; // RULE12
        `RPI_IDX_CTRL2:  reg_rd = ctrl2_q;
        default:         reg_rd = 16'h0000;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_state_q   <= M_PRE;
      pre_cnt_q   <= 6'h00;
      bit_cnt_q   <= 4'h0;
      hdr_q       <= 12'h000;
      m_rd_q      <= 1'b0;
      m_idx_q     <= 5'h00;
      m_shift_q   <= 16'h0000;
      m_wr_pend_q <= 1'b0;
      mdc_d1_q    <= 1'b0;
      mdio_o      <= 1'b0;
      mdio_oe     <= 1'b0;
    end else begin
      mdc_d1_q <= mdc_s;
      if (m_serve)
        m_wr_pend_q <= 1'b0;
      if (mdc_rise) begin                                         // RULE14
        case (m_state_q)
          M_PRE: begin
            if (mdio_s) begin
              if (pre_cnt_q != `RPI_MGMT_PRE_LEN)
                pre_cnt_q <= pre_cnt_q + 6'h01;
            end else if (pre_cnt_q == `RPI_MGMT_PRE_LEN) begin
              m_state_q <= M_HDR;
              bit_cnt_q <= 4'h0;
            end else begin
              pre_cnt_q <= 6'h00;
            end
          end
          M_HDR: begin
            hdr_q     <= hdr_full[11:0];
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hc) begin
              bit_cnt_q <= 4'h0;
              pre_cnt_q <= 6'h00;
              m_idx_q   <= hdr_full[4:0];
              m_rd_q    <= (hdr_full[11:10] == `RPI_MGMT_OP_RD);
              m_shift_q <= reg_rd(hdr_full[4:0]);
              if (hdr_hit && (hdr_full[11:10] == `RPI_MGMT_OP_RD ||
                              hdr_full[11:10] == `RPI_MGMT_OP_WR))
                m_state_q <= M_TA;
              else
                m_state_q <= M_PRE;
            end
          end
          M_TA: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h0) begin
              mdio_oe <= m_rd_q;
              mdio_o  <= 1'b0;
            end else begin
              bit_cnt_q <= 4'h0;
              if (m_rd_q) begin
                mdio_o    <= m_shift_q[15];
                m_shift_q <= {m_shift_q[14:0], 1'b0};
                m_state_q <= M_RDAT;
              end else begin
                m_state_q <= M_WDAT;
              end
            end
          end
          M_RDAT: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hf) begin
              mdio_oe   <= 1'b0;
              mdio_o    <= 1'b0;
              m_state_q <= M_PRE;
            end else begin
              mdio_o    <= m_shift_q[15];
              m_shift_q <= {m_shift_q[14:0], 1'b0};
            end
          end
          M_WDAT: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            m_shift_q <= {m_shift_q[14:0], mdio_s};
            if (bit_cnt_q == 4'hf) begin
              m_wr_pend_q <= 1'b1;
              m_state_q   <= M_PRE;
            end
          end
          default: begin
            m_state_q <= M_PRE;
            mdio_oe   <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file, wishbone wins a collision and management waits a cycle
  reg                 wr_go;
  reg  [4:0]          wr_idx;
  reg  [15:0]         wr_data;
  reg  [1:0]          wr_be;
  reg  [`RPI_EV_W-1:0] clr;
  reg  [`RPI_EV_W-1:0] ev;

  always @* begin
    wr_go   = wb_wr || m_serve;
    wr_idx  = wb_wr ? wb_adr_i[6:2] : m_idx_q;
    wr_data = wb_wr ? wb_dat_i[15:0] : m_shift_q;
    wr_be   = wb_wr ? wb_sel_i[1:0] : 2'h3;
    m_wr_ev = m_serve;
    clr     = {`RPI_EV_W{1'b0}};
    if (wr_go && wr_idx == `RPI_IDX_INT_CLR && wr_be[0])
      clr = wr_data[`RPI_EV_W-1:0];
    ev = {`RPI_EV_W{1'b0}};
    ev[`RPI_EV_RX_START] = core_rx_dv && !rx_dv_d1_q;
    ev[`RPI_EV_RX_ERR]   = core_rx_err;
    ev[`RPI_EV_TX_START] = tx_en && !tx_en_d1_q;
    ev[`RPI_EV_TX_END]   = !tx_en && tx_en_d1_q;
    ev[`RPI_EV_MGMT_WR]  = m_wr_ev;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= `RPI_CTRL_RST;
      ctrl2_q  <= `RPI_CTRL2_RST;
      int_en_q <= {`RPI_EV_W{1'b0}};
      status_q <= {`RPI_EV_W{1'b0}};
    end else begin
      // a new event beats a clear in the same cycle
      status_q <= (status_q & ~clr) | ev;                         // RULE12
      if (strap_latch) begin
        ctrl_q[`RPI_CTRL_DUPLEX_BIT] <= pin_s[6];                 // RULE8
        ctrl_q[`RPI_CTRL_SETA_BIT]   <= pin_s[4];                 // RULE9
      end else if (wr_go) begin
        case (wr_idx)
          `RPI_IDX_CTRL: begin
            if (wr_be[0])
              ctrl_q[7:0] <= wr_data[7:0];
            if (wr_be[1])
              ctrl_q[15:8] <= wr_data[15:8];
          end
          `RPI_IDX_INT_CS: begin
            if (wr_be[1])                                         // RULE12
              int_en_q <= wr_data[`RPI_INT_EN_LSB+`RPI_EV_W-1:
                                  `RPI_INT_EN_LSB];
          end
          `RPI_IDX_CTRL2: begin
            if (wr_be[0])
              ctrl2_q[7:0] <= wr_data[7:0];
            if (wr_be[1])
              ctrl2_q[15:8] <= wr_data[15:8];
          end
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wishbone answer and interrupt pin
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      // unmapped addresses answer with zero
      if (wb_req && !wb_we_i)
        wb_dat_o <= wb_adr_i[7] ? 32'h00000000
                                : {16'h0000, reg_rd(wb_adr_i[6:2])};
    end
  end

  wire irq_level = |(status_q & int_en_q);                        // RULE12

  // pin idles inactive, which is high for the default polarity
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      interrupt_output <= 1'b1;
    else if (ctrl2_q[`RPI_CTRL2_POL_BIT])                         // RULE13
      interrupt_output <= irq_level;
    else
      interrupt_output <= !irq_level;                             // RULE13
  end

endmodule // rpi_top

// ==== rtl/rpi_consts.vh ====
// constants for the reduced-interface pin block
// Notes on behaviour
// (RULE1) Receive dibits are driven on the reference clock, two bits per cycle while carrier-valid is high.
// (RULE2) Transmit dibits from the MAC are taken on the reference clock, two bits per cycle while transmit enable is high.
// (RULE3) A 50 MHz reference clock is driven out to the MAC as the timing reference for both directions.
// (RULE4) The system supplies a 25 MHz reference at the device's reference clock input; the code assumes 50 MHz (20 ns) at ref_clk.
// (RULE5) Carrier sense and receive data valid are presented together on one output.
// (RULE6) Receive errors are reported to the MAC on the receive error output.
// (RULE7) The three station address bits are captured from their straps at reset, bit 0 defaulting high and bits 1 and 2 low.
// (RULE8) The duplex strap level is latched into bit 8 of control register 0h at reset, defaulting high.
// (RULE9) The setting_a strap level is latched at reset, defaulting low.
// (RULE10) The three interface mode strap bits are latched at reset, each defaulting low.
// (RULE11) Dual-purpose strap pins are inputs only during reset and take their output function afterwards.
// (RULE12) Interrupt conditions are enabled and pending status is read through register 1Bh.
// (RULE13) Bit 9 of register 1Fh selects interrupt polarity, active low by default.
// (RULE14) Management data moves synchronously with the management clock supplied by the station manager.
// (RULE15) While the latched setting_a setting is active the receive-side outputs are left undriven.
`ifndef RPI_CONSTS_VH
`define RPI_CONSTS_VH

// timing
`define RPI_CLK_PERIOD_NS   20
`define RPI_STRAP_TIME_NS   1000

// register indices, byte address is four times the index
`define RPI_IDX_CTRL        5'h00
`define RPI_IDX_STRAP       5'h18
`define RPI_IDX_INT_CS      5'h1b
`define RPI_IDX_INT_CLR     5'h1d
`define RPI_IDX_CTRL2       5'h1f

// field positions
`define RPI_CTRL_DUPLEX_BIT 8
`define RPI_CTRL_SETA_BIT   10
`define RPI_CTRL2_POL_BIT   9
`define RPI_INT_EN_LSB      8

// reset values
`define RPI_CTRL_RST        16'h0000
`define RPI_CTRL2_RST       16'h0000

// interrupt events
`define RPI_EV_W            5
`define RPI_EV_RX_START     0
`define RPI_EV_RX_ERR       1
`define RPI_EV_TX_START     2
`define RPI_EV_TX_END       3
`define RPI_EV_MGMT_WR      4

// management frame
`define RPI_MGMT_PRE_LEN    6'h20
`define RPI_MGMT_OP_RD      2'h2
`define RPI_MGMT_OP_WR      2'h1

`endif

// ==== rtl/rpi_sync.v ====
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rpi_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // pins and result
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // rpi_sync

// ==== tb/rpi_checker.sv ====
// concurrent checks on the reduced-interface pin block ports
`timescale 1ns/10ps
module rpi_checker (
  // clock and reset
  input wire       ref_clk,
  input wire       rst_n,
  input wire       ref_clk_out,
  // register bus
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  // pins
  input wire [1:0] rxd_o,
  input wire [1:0] rxd_oe,
  input wire       crs_dv_o,
  input wire       crs_dv_oe,
  input wire       rx_er_o,
  input wire       rx_er_oe,
  input wire       tx_en,
  input wire [1:0] txd,
  // core side
  input wire [1:0] core_rx_dibit,
  input wire       core_rx_dv,
  input wire       core_rx_err,
  input wire [1:0] core_tx_dibit,
  input wire       core_tx_valid,
  input wire [2:0] station_address_strap
);
  // cycles since reset release, saturating so it never wraps
  reg [6:0] age_q;
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n) age_q <= 7'h00;
    else if (age_q != 7'h7f) age_q <= age_q + 7'h01;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  rx_valid_a: assert property (
    crs_dv_o == $past(core_rx_dv)) else $error("carrier-valid lag");
  rx_data_a: assert property (
    rxd_o == ($past(core_rx_dv) ? $past(core_rx_dibit) : 2'h0))
    else $error("receive dibit wrong");
  rx_err_a: assert property (
    rx_er_o == $past(core_rx_err)) else $error("receive error lag");
  tx_take_a: assert property (
    core_tx_valid == $past(tx_en) &&
    core_tx_dibit == ($past(tx_en) ? $past(txd) : 2'h0))
    else $error("transmit dibit wrong");
  ref_clk_a: assert property (
    @(negedge ref_clk) ref_clk_out) else $error("reference clock off");
  bus_ack_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle");
  strap_win_a: assert property (
    age_q < 7'h32 |-> !crs_dv_oe && !rx_er_oe && rxd_oe == 2'h0)
    else $error("pin driven in strap window");
  oe_group_a: assert property (
    rx_er_oe == crs_dv_oe && rxd_oe == {2{crs_dv_oe}})
    else $error("enables disagree");
  strap_hold_a: assert property (
    age_q > 7'h33 |-> $stable(station_address_strap))
    else $error("address moved after latch");
endmodule // rpi_checker

// ==== tb/rpi_mac_model.sv ====
// mac-side partner: pin pulls, transmit dibits, management frames
`timescale 1ns/10ps
module rpi_mac_model (
  // reference clock
  input  wire       ref_clk,
  // receive pins from the device
  input  wire [1:0] rxd_o,
  input  wire [1:0] rxd_oe,
  input  wire       crs_dv_o,
  input  wire       crs_dv_oe,
  input  wire       rx_er_o,
  input  wire       rx_er_oe,
  output wire [1:0] rxd_w,
  output wire       crs_dv_w,
  output wire       rx_er_w,
  // transmit pins toward the device
  output reg        tx_en,
  output reg  [1:0] txd,
  // management
  output reg        mdc,
  output wire       mdio_w,
  input  wire       mdio_o,
  input  wire       mdio_oe
);
  reg md_q = 1'b1;
  initial tx_en = 1'b0;
  initial txd = 2'h0;
  initial mdc = 1'b0;
  // released pins fall to their pull level
  assign rxd_w[0] = rxd_oe[0] ? rxd_o[0] : 1'b1;
  assign rxd_w[1] = rxd_oe[1] ? rxd_o[1] : 1'b0;
  assign crs_dv_w = crs_dv_oe ? crs_dv_o : 1'b0;
  assign rx_er_w = rx_er_oe ? rx_er_o : 1'b0;
  assign mdio_w = mdio_oe ? mdio_o : md_q;
  // lsb dibit first; idle txd is inverted junk, not zero
  task send(input [7:0] b);
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge ref_clk);
      tx_en <= 1'b1;
      txd <= b[2*i+:2];
    end
    @(posedge ref_clk);
    tx_en <= 1'b0;
    txd <= ~b[7:6];
  endtask
  // one frame; mdc stands still outside it, read bits taken on mdc rise
  task mgmt(input [1:0] op, input [4:0] pa, input [4:0] ra,
            input [15:0] d, output [15:0] q);
    reg [63:0] f;
    integer i;
    f = {32'hffffffff, 2'h1, op, pa, ra, 2'h2, d};
    // read: released for turnaround and data, the pull-up shows
    if (op == 2'h2)
      f[17:0] = 18'h3ffff;
    q = 16'h0000;
    #7;
    for (i = 63; i >= 0; i = i - 1) begin
      md_q = f[i];
      #80 mdc = 1'b1;
      if (i < 16)
        q[i] = mdio_w;
      #80 mdc = 1'b0;
    end
    md_q = 1'b1;
  endtask
endmodule // rpi_mac_model

// ==== tb/rpi_top_bench.sv ====
// self-checking bench for the reduced-interface pin block
`timescale 1ns/10ps
module rpi_top_bench;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         req, we, rdv, rerr;
  reg  [7:0]  adr, txcap;
  reg  [3:0]  sel;
  reg  [31:0] wdat;
  reg  [1:0]  rdib;
  wire [31:0] rdat;
  wire [1:0]  rxd_o, rxd_oe, rxd_w, txd, tdib;
  wire        ack, crs_o, crs_oe, crs_w, er_o, er_oe, er_w, irq;
  wire        tx_en, mdc, mdio_w, mdio_o, mdio_oe, tval;
  wire [2:0]  sa;
  integer     error_cnt = 0;
  integer     checks_done = 0;
  integer     i;
  reg  [15:0] mq;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (tval) txcap <= {tdib, txcap[7:2]};
  rpi_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ref_clk_out(), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .rxd_i(rxd_w),
    .crs_dv_o(crs_o), .crs_dv_oe(crs_oe), .crs_dv_i(crs_w),
    .rx_er_o(er_o), .rx_er_oe(er_oe), .rx_er_i(er_w), .tx_en(tx_en),
    .txd(txd), .station_address_bit0_pin(1'b1),
    .station_address_bit1_pin(1'b0), .interface_mode_strap_bit0(1'b1),
    .interface_mode_strap_bit1(1'b0), .mdc(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .interrupt_output(irq),
    .core_rx_dibit(rdib), .core_rx_dv(rdv), .core_rx_err(rerr),
    .core_tx_dibit(tdib), .core_tx_valid(tval),
    .station_address_strap(sa));
  rpi_mac_model mac (.ref_clk(ref_clk), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
    .crs_dv_o(crs_o), .crs_dv_oe(crs_oe), .rx_er_o(er_o),
    .rx_er_oe(er_oe), .rxd_w(rxd_w), .crs_dv_w(crs_w), .rx_er_w(er_w),
    .tx_en(tx_en), .txd(txd), .mdc(mdc), .mdio_w(mdio_w),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe));
  ////////////////////////////////////////////////////////////
  task final_report;
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // classic cycle; no latency assumed, only a bounded wait
  task wb(input w, input [7:0] a, input [31:0] d, input [3:0] s,
          output [31:0] q);
    integer n;
    @(posedge ref_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    req <= 1'b0;
    if (n >= 20) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    reg [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    reg [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task pins(input [1:0] d, input v, input er);
    @(posedge ref_clk);
    #1;
    chk("rxd pin", d, rxd_w);
    chk("crs_dv pin", v, crs_w);
    chk("rx_er pin", er, er_w);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {req, we, rdv, rerr, adr, sel, wdat, rdib} = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (60) @(posedge ref_clk);
    chk("address", 32'h1, sa);
    rd(8'h60, 32'h0009);
    rd(8'h00, 32'h0100);
    pins(2'h0, 1'b0, 1'b0);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge ref_clk);
      rdv <= 1'b1;
      rdib <= i[1:0];
      rerr <= i[0];
      pins(i[1:0], 1'b1, i[0]);
    end
    @(posedge ref_clk);
    rdv <= 1'b0;
    rerr <= 1'b0;
    mac.send(8'hb4);
    repeat (2) @(posedge ref_clk);
    chk("tx byte", 32'hb4, txcap);
    rd(8'h6c, 32'h000f);
    chk("interrupt", 32'h1, irq);
    wr(8'h6c, 32'h1f00, 4'h1);
    rd(8'h6c, 32'h000f);
    wr(8'h6c, 32'h1f00, 4'h3);
    rd(8'h6c, 32'h1f0f);
    chk("interrupt", 32'h0, irq);
    wr(8'h74, 32'h000f, 4'h1);
    rd(8'h6c, 32'h1f00);
    chk("interrupt", 32'h1, irq);
    wr(8'h80, 32'hffff, 4'hf);
    rd(8'h80, 32'h0);
    mac.mgmt(2'h1, 5'h01, 5'h1f, 16'h0200, mq);
    repeat (6) @(posedge ref_clk);
    rd(8'h7c, 32'h0200);
    mac.mgmt(2'h2, 5'h01, 5'h1f, 16'h0000, mq);
    chk("mgmt read", 32'h0200, mq);
    chk("mdio enable", 32'h0, mdio_oe);
    mac.mgmt(2'h1, 5'h03, 5'h1f, 16'h0000, mq);
    repeat (6) @(posedge ref_clk);
    rd(8'h7c, 32'h0200);
    rd(8'h6c, 32'h1f10);
    chk("interrupt", 32'h1, irq);
    wr(8'h74, 32'h0010, 4'h1);
    rd(8'h6c, 32'h1f00);
    chk("interrupt", 32'h0, irq);
    wr(8'h00, 32'h0500, 4'h3);
    rd(8'h00, 32'h0500);
    rdv <= 1'b1;
    rdib <= 2'h2;
    @(posedge ref_clk);
    pins(2'h1, 1'b0, 1'b0);
    final_report;
  end
endmodule // rpi_top_bench
bind rpi_top rpi_checker ck (.ref_clk(ref_clk), .rst_n(rst_n),
  .ref_clk_out(ref_clk_out), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
  .crs_dv_o(crs_dv_o), .crs_dv_oe(crs_dv_oe), .rx_er_o(rx_er_o),
  .rx_er_oe(rx_er_oe), .tx_en(tx_en), .txd(txd),
  .core_rx_dibit(core_rx_dibit), .core_rx_dv(core_rx_dv),
  .core_rx_err(core_rx_err), .core_tx_dibit(core_tx_dibit),
  .core_tx_valid(core_tx_valid),
  .station_address_strap(station_address_strap));
